// >>> pic_pkg.sv
// package: constants and carrier types for the pad impedance calibrator
package pic_pkg;
	localparam int          CODE_W        = 5;
	localparam logic [4:0]  CODE_ALL_ONES = 5'h1f;
	localparam logic [4:0]  CODE_ZERO     = 5'h00;
	localparam logic [4:0]  AVG_RESET     = 5'h10;
	localparam int          CLK_MHZ       = 25;
	// settle times, printed as cycles of the core clock
	localparam int          SETTLE_CYC    = 64;
	localparam int          CMP_CYC       = 16;
	localparam int          WAIT_W        = 7;
	localparam logic [6:0]  SETTLE_LAST   = 7'(SETTLE_CYC - 1);
	localparam logic [6:0]  CMP_LAST      = 7'(CMP_CYC - 1);

	typedef enum logic [3:0] {
		PIC_LOAD   = 4'h1,
		PIC_SETTLE = 4'h2,
		PIC_CMP    = 4'h4,
		PIC_DECIDE = 4'h8
	} pic_state_t;

	// software override port
	typedef struct packed {
		logic       override_enable;
		logic [4:0] value;
	} pic_ovrd_t;

	// sensor pad drive group
	typedef struct packed {
		logic       run;
		logic       cmp_en_n;
		logic [4:0] code_n;
	} pic_sensor_t;
endpackage

// >>> pic_sync3.sv
// three-flop synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none
module pic_sync3 (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_ce,
	// pin in, filtered level out
	input  wire logic i_pin,
	output logic      o_level
);
	logic s1;
	logic s2;
	logic s3;

	// s1 is read only by s2; level moves once s2 and s3 agree
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			o_level <= 1'b0;
		end else if (i_ce) begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				o_level <= s3;
			end
		end
	end
endmodule
`default_nettype wire

// >>> pic_calibrator.sv
// pad impedance calibrator: counting converter, averaging filter, override
`timescale 1ns/1ns
`default_nettype none
module pic_calibrator
	import pic_pkg::*;
(
	// clock, reset, enable
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// software override and test
	input  wire pic_ovrd_t  i_ovrd,
	input  wire logic       i_base_test,
	// sensor pad comparator, from the pad ring
	input  wire logic       i_count_up,
	// sensor pad control
	output pic_sensor_t     o_sensor,
	output logic            o_base_off,
	// pad drivers and readback
	output logic [4:0]      o_drive_code_n,
	output logic [4:0]      o_calc_code,
	output logic            o_match_seen
);
	pic_state_t state;
	pic_state_t next_state;
	logic [4:0] trial;
	logic [4:0] avg;
	logic [6:0] wait_cnt;
	logic       match;
	logic       wait_done;

	// the comparator output is analog-derived: filtered before use
	// three flops plus agreement cost about four cycles of the compare wait
	pic_sync3 u_cmp_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_pin    (i_count_up),
		.o_level  (match)
	);

	// end of the settle or compare wait; load and decide never read it
	assign wait_done = (state == PIC_SETTLE) ? (wait_cnt == SETTLE_LAST)
	                                         : (wait_cnt == CMP_LAST);

	// converter sequence; passes repeat forever
	always_comb begin
		next_state = state;
		case (state)
			PIC_LOAD:   next_state = PIC_SETTLE;
			PIC_SETTLE: if (wait_done) next_state = PIC_CMP;
			PIC_CMP:    if (wait_done) next_state = PIC_DECIDE;
			PIC_DECIDE: begin
				if (match || trial == CODE_ZERO) begin
					next_state = PIC_LOAD;
				end else begin
					next_state = PIC_CMP;
				end
			end
			default:    next_state = PIC_LOAD;
		endcase
	end

	// state register; frozen while the clock enable is low
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= PIC_LOAD;
		end else if (i_ce) begin
			state <= next_state;
		end
	end

	// settle and compare wait counter clears on every state change
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_cnt <= '0;
		end else if (i_ce) begin
			if (next_state != state) begin
				wait_cnt <= '0;
			end else if (!wait_done) begin
				wait_cnt <= wait_cnt + 7'h01;
			end
		end
	end

	// trial counter: all ones at start, step down on no match
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			trial <= CODE_ALL_ONES;
		end else if (i_ce) begin
			if (state == PIC_LOAD) begin
				trial <= CODE_ALL_ONES;
			end else if (state == PIC_DECIDE && !match && trial != CODE_ZERO) begin
				trial <= trial - 5'h01;
			end
		end
	end

	// averaging filter; one step per match limits noise swings
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			avg <= AVG_RESET;
		end else if (i_ce && state == PIC_DECIDE) begin
			if (match) begin
				if (trial > avg) begin
					avg <= avg + 5'h01;
				end else if (trial < avg) begin
					avg <= avg - 5'h01;
				end
			end else if (trial == CODE_ZERO) begin
				avg <= i_ovrd.value;
			end
		end
	end

	// sensor pad controls; replica code is the inverted trial value
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sensor <= '{run: 1'b0, cmp_en_n: 1'b1, code_n: CODE_ZERO};
		end else if (i_ce) begin
			o_sensor.run      <= 1'b1;
			o_sensor.cmp_en_n <= !(next_state == PIC_CMP);
			o_sensor.code_n   <= ~trial;
		end
	end

	// pad drive code and readback; override wins at the pad code when enabled, readback always shows the average
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_drive_code_n <= ~AVG_RESET;
			o_calc_code    <= AVG_RESET;
			o_base_off     <= 1'b0;
			o_match_seen   <= 1'b0;
		end else if (i_ce) begin
			// inverted binary weighting, active low bits
			o_drive_code_n <= i_ovrd.override_enable ? ~i_ovrd.value : ~avg;
			o_calc_code    <= avg;
			o_base_off     <= i_base_test;
			o_match_seen   <= (state == PIC_DECIDE) && match;
		end
	end

	// tristate release lives in each control pad; nothing to drive here

	// override path and averaging filter
	a_override_path: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && i_ovrd.override_enable ##1 1'b1 |-> o_drive_code_n == ~$past(i_ovrd.value))
		else $error("override value did not reach the pad code");
	a_avg_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && match |=> (avg - $past(avg) <= 5'h01)
		|| ($past(avg) - avg <= 5'h01))
		else $error("average moved by more than one step");
	a_avg_up: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && match && trial > avg |=> avg == $past(avg) + 5'h01)
		else $error("average did not step up toward a larger match");
	a_avg_down: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && match && trial < avg |=> avg == $past(avg) - 5'h01)
		else $error("average did not step down toward a smaller match");
	a_avg_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && match && trial == avg |=> $stable(avg))
		else $error("average changed on a match equal to it");

	// sequence timing and trial counter
	a_settle_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && $rose(state == PIC_SETTLE) |-> wait_cnt == 7'h00)
		else $error("settle wait did not start from zero");
	a_settle_exit: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_SETTLE && wait_cnt == SETTLE_LAST |=> state == PIC_CMP)
		else $error("settle wait did not end after its last cycle");
	a_cmp_exit: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_CMP && wait_cnt == CMP_LAST |=> state == PIC_DECIDE)
		else $error("compare wait did not end after its last cycle");
	a_cmp_window: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_sensor.cmp_en_n == (state != PIC_CMP))
		else $error("comparator enable outside the compare wait");
	a_load_ones: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_LOAD |=> trial == CODE_ALL_ONES)
		else $error("trial counter not loaded with all ones");
	a_zero_default: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && !match && trial == CODE_ZERO
		|=> avg == $past(i_ovrd.value))
		else $error("unmatched pass did not load the default code");
	a_decrement: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce && state == PIC_DECIDE && !match && trial != CODE_ZERO
		|=> trial == $past(trial) - 5'h01)
		else $error("trial counter did not step down after no match");

	// pad controls, readback and clock enable
	a_replica_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce |=> o_sensor.code_n == ~$past(trial))
		else $error("replica code is not the inverted trial value");
	a_readback: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce |=> o_calc_code == $past(avg))
		else $error("readback differs from the average");
	a_base_test: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce |=> o_base_off == $past(i_base_test))
		else $error("base transistor control did not follow the test input");
	a_drive_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce |=> o_drive_code_n == ($past(i_ovrd.override_enable)
			? ~$past(i_ovrd.value) : ~$past(avg)))
		else $error("pad code is neither the override nor the inverted average");
	a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!i_ce |=> $stable(state) && $stable(trial) && $stable(avg) && $stable(o_drive_code_n))
		else $error("state moved while the clock enable was low");
	a_match_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_ce |=> o_match_seen == ($past(state) == PIC_DECIDE && $past(match)))
		else $error("match pulse does not follow a matched decision");
endmodule
`default_nettype wire

// >>> pic_sensor_model.sv
// sensor pad model: replica network and comparator against a target trial code
`timescale 1ns/1ns
`default_nettype none
module pic_sensor_model
	import pic_pkg::*;
(
	// clock and pad control
	input  wire logic        i_clk,
	input  wire pic_sensor_t i_sensor,
	// trial code where replica meets the resistor; above 31 never meets
	input  wire logic [5:0]  i_target,
	// comparator result
	output logic             o_count_up
);
	logic tgl = 1'b0;
	// a disabled comparator has no steady level, so show a changing one
	always @(posedge i_clk) tgl <= ~tgl;
	// match once the counted-down trial has reached the target
	// a target with bit 5 set stands for a resistor that no trial code can meet
	assign o_count_up = (i_sensor.run && !i_sensor.cmp_en_n) ?
		(!i_target[5] && ({1'b0, ~i_sensor.code_n} <= i_target)) : tgl;
endmodule
`default_nettype wire

// >>> tb_pic_calibrator.sv
// bench: calibrator with sensor model, checked against an averaging model
`timescale 1ns/1ns
`default_nettype none
module tb_pic_calibrator
	import pic_pkg::*;
;
	logic        i_clk = 1'b0;
	logic        i_resetn;
	logic        ce;
	pic_ovrd_t   i_ovrd;
	logic        i_base_test;
	logic        cup;
	logic [5:0]  target;
	pic_sensor_t sensor;
	logic        boff;
	logic [4:0]  drv_n;
	logic [4:0]  calc;
	logic        match;
	logic [7:0]  lfsr;
	logic [4:0]  ov [3];
	int          mismatches;
	int          comparisons;
	int          avg;
	int          n;
	pic_calibrator uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_ovrd(i_ovrd),
		.i_base_test(i_base_test), .i_count_up(cup), .o_sensor(sensor), .o_base_off(boff),
		.o_drive_code_n(drv_n), .o_calc_code(calc), .o_match_seen(match));
	pic_sensor_model pad (.i_clk(i_clk), .i_sensor(sensor), .i_target(target), .o_count_up(cup));
	always #20 i_clk = ~i_clk;
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// each matched pass steps the model average once; wait is bounded
	task automatic converge(input int steps);
		repeat (steps) begin
			n = 0;
			do begin
				@(negedge i_clk);
				n++;
			end while (match !== 1'b1 && n < 3000);
			check_bit("match", 1'b1, match);
			avg = avg + int'(target > avg) - int'(target < avg);
			// readback and pad code register the new average one edge after the pulse
			@(negedge i_clk);
			check("calc", 5'(avg), calc);
			check("drive", ~5'(avg), drv_n);
		end
	endtask
	initial begin
		i_resetn = 1'b0;
		ce = 1'b1;
		i_ovrd = '0;
		i_base_test = 1'b0;
		target = 6'h09;
		lfsr = 8'h55;
		mismatches = 0;
		comparisons = 0;
		avg = 16;
		repeat (6) @(negedge i_clk);
		check("calc", AVG_RESET, calc);
		check("drive", ~AVG_RESET, drv_n);
		i_resetn = 1'b1;
		converge(3);
		// random targets, then one equal to the average so it must hold
		repeat (3) begin
			lfsr = lfsr_next(lfsr);
			target = 6'(1 + lfsr % 30);
			converge(3);
		end
		target = 6'(avg);
		converge(2);
		$display("done averaging");
		// field kept far from the average so a single step cannot reach it
		i_ovrd.value = 5'(avg) ^ 5'h15;
		target = 6'h20;
		n = 0;
		while (calc !== i_ovrd.value && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		check("calc", i_ovrd.value, calc);
		avg = int'(i_ovrd.value);
		$display("done unmatched");
		// pads take the field a cycle later while readback keeps the average
		lfsr = lfsr_next(lfsr);
		ov = '{5'h1f, 5'h00, lfsr[4:0]};
		for (int k = 0; k < 3; k++) begin
			i_ovrd.override_enable = 1'b1;
			i_ovrd.value = ov[k];
			i_base_test = ~k[0];
			@(negedge i_clk);
			check("drive", ~ov[k], drv_n);
			check_bit("base", ~k[0], boff);
			check("calc", 5'(avg), calc);
		end
		i_ovrd.override_enable = 1'b0;
		@(negedge i_clk);
		check("drive", ~5'(avg), drv_n);
		// clock enable low: a new override and test level must not reach the pads
		ce = 1'b0;
		i_ovrd.override_enable = 1'b1;
		i_base_test = 1'b0;
		repeat (2) @(negedge i_clk);
		check("drive", ~5'(avg), drv_n);
		check_bit("base", 1'b1, boff);
		ce = 1'b1;
		i_ovrd.override_enable = 1'b0;
		$display("done override");
		// reset in mid-run; passes then restart unprompted from mid-scale
		i_resetn = 1'b0;
		#5;
		check("calc", AVG_RESET, calc);
		check("drive", ~AVG_RESET, drv_n);
		check_bit("base", 1'b0, boff);
		@(negedge i_clk);
		i_resetn = 1'b1;
		avg = 16;
		target = 6'h14;
		converge(2);
		$display("done restart");
		results();
	end
	// watchdog: all passes together stay far below this span
	initial begin
		repeat (40000) @(posedge i_clk);
		mismatches++;
		$display("FAIL watchdog expected done seen timeout");
		results();
	end
endmodule
`default_nettype wire
